// *** logic/conv_ctrl.v ***
// Control and register logic of a 10-bit successive-approximation converter.
// Assumes an analog core that samples on conv_sample and delivers its result on
// analog_result by the last converter clock of a conversion.
//
// Function
// R1: Reference and channel writes during a conversion apply only after it completes.
// R2: Reference code 00 external pin, 01 supply, 11 internal 1.1V; 10 reserved.
// R3: Alignment bit set left-aligns, clear right-aligns; change acts immediately.
// R4: Bit 4 of the reference and channel register always reads zero.
// R5: Channel 0-7 pins, 8 temperature, 14 bandgap, 15 ground; 9-13 reserved.
// R6: Enable bit switches converter on; clearing aborts a running conversion.
// R7: Start bit launches one conversion; in free running only the first.
// R8: First conversion after enable takes 25 converter clocks, later ones 13.
// R9: Start bit reads one during conversion, zero after; writing zero does nothing.
// R10: With auto trigger set, rising edge of chosen trigger starts a conversion.
// R11: Done flag sets on completion; interrupt needs done enable and global enable.
// R12: Done flag clears on vector execution or by writing one to it.
// R13: Divider code 000/001 divide by 2, then 4 to 128 for 010-111.
// R14: Right: bits 9:8 high byte 1:0. Left: 9:2 high, 1:0 low 7:6.
// R15: After reading low byte, result updates are held until high byte read.
// R16: Software reads low byte before high, or only high for 8-bit left-aligned.
// R17: Trigger source selection matters only while auto trigger is enabled.
// R18: Switching from clear source to set source makes a rising trigger edge.
// R19: Selecting free running never creates a trigger event by itself.
// R20: Trigger codes: free run, comparator, ext int 0, T0 cmpA, T0 ovf, T1 cmpB, ovf, capture.
// R21: Pin disable bits 5:0 turn off input buffers and force port bits zero.
// R22: Software writes zeros to reserved bits of control B and pin disable.
// R23: Entering low-noise sleep starts a conversion when enabled, idle, single mode.
// R24: In free running mode a new conversion starts when the previous completes.
`timescale 1ns/1ps
`include "conv_ctrl_map.vh"

module conv_ctrl (
  input  wire         clk_sys,
  input  wire         rst,
  // Avalon-MM slave
  input  wire [9:0]   avs_address,
  input  wire         avs_read,
  input  wire         avs_write,
  input  wire [31:0]  avs_writedata,
  input  wire [3:0]   avs_byteenable,
  output reg  [31:0]  avs_readdata,
  output reg          avs_waitrequest,
  output reg  [1:0]   avs_response,
  // Processor side
  input  wire         global_irq_enable,
  input  wire         irq_vector_ack,
  input  wire         sleep_noise_halt,
  output reg          conv_irq,
  // Trigger flags (comparator, ext int 0, T0 cmpA, T0 ovf, T1 cmpB, T1 ovf, T1 capture)
  input  wire [6:0]   trigger_flags,
  // Analog core
  input  wire [9:0]   analog_result,
  output reg          conv_enable,
  output reg          conv_sample,
  output reg  [1:0]   ref_select,
  output reg  [3:0]   input_channel_select,
  output reg          conv_clk_en,
  // Digital input buffers
  input  wire [5:0]   port_pin_raw,
  output reg  [5:0]   pin_input_disable,
  output reg  [5:0]   port_pin_value
);

  // --------------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------------
  // Divider terminal count: division factor minus one
  function [6:0] div_last;
    input [2:0] code;
    begin
      case (code)
        3'd0, 3'd1: div_last = 7'h01; // R13
        3'd2:       div_last = 7'h03;
        3'd3:       div_last = 7'h07;
        3'd4:       div_last = 7'h0F;
        3'd5:       div_last = 7'h1F;
        3'd6:       div_last = 7'h3F;
        default:    div_last = 7'h7F;
      endcase
    end
  endfunction

  // Selected trigger level; free running maps to constant low
  function trig_level;
    input [2:0] code;
    input [6:0] flags;
    begin
      if (code == `TRIG_FREE_RUN)
        trig_level = 1'b0; // R19
      else
        trig_level = flags[code - 3'd1]; // R20
    end
  endfunction

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  reg  [1:0]  ref_sel_r;
  reg         left_align_r;
  reg  [3:0]  chan_sel_r;
  reg         enable_r;
  reg         auto_r;
  reg         done_r;
  reg         done_ie_r;
  reg  [2:0]  div_sel_r;
  reg  [2:0]  trig_sel_r;
  reg  [5:0]  pin_dis_r;
  reg  [9:0]  result_r;
  reg         read_lock_r;
  reg         busy_r;
  reg         first_r;
  reg  [4:0]  cycle_r;
  reg  [6:0]  div_cnt_r;
  reg         trig_prev_r;
  reg         halt_prev_r;
  reg         rd_phase_r;

  localparam ST_IDLE = 1'b0;
  localparam ST_DONE = 1'b1;

  wire [7:0] idx      = avs_address[9:2];
  wire       wr_hit   = avs_write && !avs_waitrequest && avs_byteenable[0];
  wire       rd_hit   = avs_read && !avs_waitrequest;
  wire [7:0] wbyte    = avs_writedata[7:0];
  wire       wr_ca    = wr_hit && idx == `IDX_CONTROL_A;
  wire       wr_mux   = wr_hit && idx == `IDX_REF_CHAN;
  wire       tick     = div_cnt_r == div_last(div_sel_r);
  wire [4:0] conv_len = first_r ? `CONV_CYCLES_FIRST : `CONV_CYCLES_NORMAL;
  wire       finish   = busy_r && tick && cycle_r == conv_len;
  wire       en_nxt   = wr_ca ? wbyte[`CA_ENABLE] : enable_r;
  wire       trig_now = trig_level(trig_sel_r, trigger_flags);
  wire       trig_edge = auto_r && trig_now && !trig_prev_r; // R10 R17 R18
  wire       sleep_go = sleep_noise_halt && !halt_prev_r && !auto_r; // R23
  wire       free_go  = finish && auto_r && trig_sel_r == `TRIG_FREE_RUN; // R24
  wire       sw_go    = wr_ca && wbyte[`CA_START]; // R7
  wire       go       = en_nxt && !busy_r && (sw_go || trig_edge || sleep_go);
  wire [7:0] high_byte = left_align_r ? result_r[9:2] : {6'h00, result_r[9:8]}; // R3 R14
  wire [7:0] low_byte  = left_align_r ? {result_r[1:0], 6'h00} : result_r[7:0]; // R14

  // --------------------------------------------------------------------------
  // Bus slave: one wait cycle, then answer
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      rd_phase_r      <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      avs_response    <= 2'b00;
    end else begin
      avs_waitrequest <= 1'b1;
      if ((avs_read || avs_write) && !rd_phase_r && avs_waitrequest) begin
        rd_phase_r      <= 1'b1;
        avs_waitrequest <= 1'b0;
        avs_response    <= 2'b00;
        avs_readdata    <= 32'h0000_0000;
        case (idx)
          `IDX_RESULT_LOW:  avs_readdata[7:0] <= low_byte;
          `IDX_RESULT_HIGH: avs_readdata[7:0] <= high_byte;
          `IDX_CONTROL_A:   avs_readdata[7:0] <= {enable_r, busy_r, auto_r, done_r, // R9
                                                  done_ie_r, div_sel_r};
          `IDX_REF_CHAN:    avs_readdata[7:0] <= {ref_sel_r, left_align_r, 1'b0, // R4
                                                  chan_sel_r};
          `IDX_CONTROL_B:   avs_readdata[7:0] <= {5'h00, trig_sel_r};
          `IDX_PIN_DISABLE: avs_readdata[7:0] <= {2'b00, pin_dis_r};
          default:          avs_response      <= 2'b10;
        endcase
      end else begin
        rd_phase_r <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      ref_sel_r    <= 2'b00;
      left_align_r <= 1'b0;
      chan_sel_r   <= 4'h0;
      enable_r     <= 1'b0;
      auto_r       <= 1'b0;
      done_ie_r    <= 1'b0;
      div_sel_r    <= 3'h0;
      trig_sel_r   <= 3'h0;
      pin_dis_r    <= 6'h00;
    end else if (wr_hit) begin
      case (idx)
        `IDX_REF_CHAN: begin
          ref_sel_r    <= wbyte[7:6];
          left_align_r <= wbyte[5]; // R3
          chan_sel_r   <= wbyte[3:0];
        end
        `IDX_CONTROL_A: begin
          enable_r  <= wbyte[`CA_ENABLE]; // R6
          auto_r    <= wbyte[`CA_AUTO];
          done_ie_r <= wbyte[`CA_DONE_IE];
          div_sel_r <= wbyte[2:0];
        end
        `IDX_CONTROL_B:   trig_sel_r <= wbyte[2:0];
        `IDX_PIN_DISABLE: pin_dis_r  <= wbyte[5:0]; // Reserved bits dropped; R22 is software's
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Prescaler and conversion sequencer
  // --------------------------------------------------------------------------
  // Prescaler runs only while enabled so a conversion aligns to a clean edge
  always @(posedge clk_sys) begin
    if (rst || !enable_r || tick)
      div_cnt_r <= 7'h00;
    else
      div_cnt_r <= div_cnt_r + 7'h01;
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      busy_r      <= 1'b0;
      first_r     <= 1'b1;
      cycle_r     <= 5'd0;
      done_r      <= 1'b0;
      result_r    <= 10'h000;
      read_lock_r <= 1'b0;
      trig_prev_r <= 1'b0;
      halt_prev_r <= 1'b0;
    end else begin
      trig_prev_r <= trig_now;
      halt_prev_r <= sleep_noise_halt;
      if (!en_nxt) begin
        busy_r  <= 1'b0; // R6
        first_r <= 1'b1; // R8
      end else if (go) begin
        busy_r  <= 1'b1;
        cycle_r <= 5'd0;
      end else if (busy_r && tick) begin
        if (finish) begin
          first_r <= 1'b0;
          cycle_r <= 5'd0;
          busy_r  <= free_go; // R24
        end else begin
          cycle_r <= cycle_r + 5'd1; // R8
        end
      end
      // Set beats both clear paths
      if (finish) begin
        done_r <= 1'b1; // R11
        if (!read_lock_r)
          result_r <= analog_result; // R15
      end else if ((wr_ca && wbyte[`CA_DONE]) || irq_vector_ack) begin
        done_r <= 1'b0; // R12
      end
      if (rd_hit && idx == `IDX_RESULT_LOW)
        read_lock_r <= 1'b1; // R15
      else if (rd_hit && idx == `IDX_RESULT_HIGH)
        read_lock_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rst) begin
      conv_irq             <= 1'b0;
      conv_enable          <= 1'b0;
      conv_sample          <= 1'b0;
      ref_select           <= `REF_EXT_PIN;
      input_channel_select <= 4'h0;
      conv_clk_en          <= 1'b0;
      pin_input_disable    <= 6'h00;
      port_pin_value       <= 6'h00;
    end else begin
      conv_irq    <= done_r && done_ie_r && global_irq_enable; // R11
      conv_enable <= enable_r;
      conv_clk_en <= enable_r && tick;
      conv_sample <= busy_r && tick && cycle_r == `SAMPLE_AT_CYCLE;
      // Selection latched only when idle or on the finishing tick, so a conversion keeps its inputs
      if (!busy_r || finish) begin
        ref_select           <= ref_sel_r; // R1 R2
        input_channel_select <= chan_sel_r; // R1 R5
      end
      pin_input_disable <= pin_dis_r; // R21
      port_pin_value    <= port_pin_raw & ~pin_dis_r; // R21
    end
  end

endmodule // conv_ctrl

// *** logic/conv_ctrl_map.vh ***
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes an Avalon-MM slave with 32-bit data; each register sits in one aligned word.
`ifndef CONV_CTRL_MAP_VH
`define CONV_CTRL_MAP_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_RESULT_LOW      8'h78
`define IDX_RESULT_HIGH     8'h79
`define IDX_CONTROL_A       8'h7A
`define IDX_REF_CHAN        8'h7C
`define IDX_CONTROL_B       8'h7B
`define IDX_PIN_DISABLE     8'h7E
`define ADDR_W              10

// ----------------------------------------------------------------------------
// Control A fields
// ----------------------------------------------------------------------------
`define CA_ENABLE           7
`define CA_START            6
`define CA_AUTO             5
`define CA_DONE             4
`define CA_DONE_IE          3

// ----------------------------------------------------------------------------
// Reference select codes, channel codes, trigger codes
// ----------------------------------------------------------------------------
`define REF_EXT_PIN         2'b00
`define REF_SUPPLY          2'b01
`define REF_RESERVED        2'b10
`define REF_INTERNAL        2'b11
`define CH_TEMP             4'h8
`define CH_BANDGAP          4'hE
`define CH_GROUND           4'hF
`define TRIG_FREE_RUN       3'h0

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RESET_BYTE          8'h00
`define CONV_CYCLES_FIRST   5'd25
`define CONV_CYCLES_NORMAL  5'd13
`define SAMPLE_AT_CYCLE     5'd1

`endif

// *** sim/conv_ctrl_assertions.sv ***
// Concurrent checks on the converter control block ports.
// Assumes a bind by name from the bench top file.
`timescale 1ns/1ps
module conv_ctrl_assertions (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [1:0]  avs_response,
  input wire logic        global_irq_enable,
  input wire logic        conv_irq,
  input wire logic        conv_enable,
  input wire logic        conv_sample,
  input wire logic [1:0]  ref_select,
  input wire logic [3:0]  input_channel_select,
  input wire logic        conv_clk_en,
  input wire logic [5:0]  pin_input_disable,
  input wire logic [5:0]  port_pin_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_ANSWER: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  AST_ONE_CYCLE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_RESP: assert property (!avs_waitrequest |-> avs_response == 2'b00 || avs_response == 2'b10)
    else $error("illegal response code");
  AST_UPPER_ZERO: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read data not zero");
  AST_IRQ_GIE: assert property (conv_irq |-> $past(global_irq_enable))
    else $error("interrupt without global enable");
  AST_SAMPLE_ON: assert property (conv_sample |-> conv_enable)
    else $error("sample while converter off");
  AST_DIV_MIN: assert property (conv_clk_en |=> !conv_clk_en)
    else $error("converter clock faster than half rate");
  AST_HOLD_SEL: assert property (conv_sample |=> ($stable(ref_select) && $stable(input_channel_select))[*8])
    else $error("selection changed during conversion");
  AST_PIN_MASK: assert property ($stable(pin_input_disable) |-> (port_pin_value & pin_input_disable) == 6'h00)
    else $error("disabled pin reads one");
  COV_SAMPLE: cover property (conv_sample);
  COV_IRQ: cover property ($rose(conv_irq));
  COV_UNMAPPED: cover property (!avs_waitrequest && avs_response == 2'b10);
endmodule // conv_ctrl_assertions

// *** sim/test_conv_ctrl.sv ***
// Directed self-checking bench for the converter control block.
// Assumes the register map header and a 25 MHz clock with synchronous reset.
`timescale 1ns/1ps
`include "conv_ctrl_map.vh"
module test_conv_ctrl;
  logic        clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        global_irq_enable = 1'b1, irq_vector_ack = 1'b0, sleep_noise_halt = 1'b0;
  logic [9:0]  avs_address = 10'h000, analog_result = 10'h2A5;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [6:0]  trigger_flags = 7'h00;
  logic [5:0]  port_pin_raw = 6'h3F;
  wire  [31:0] avs_readdata;
  wire  [1:0]  avs_response, ref_select;
  wire  [3:0]  input_channel_select;
  wire  [5:0]  pin_input_disable, port_pin_value;
  wire         avs_waitrequest, conv_irq, conv_enable, conv_sample, conv_clk_en;
  logic [1:0]  r, resp;
  logic [7:0]  v;
  int          i, n1, n2, miscompares = 0, check_count = 0;
  int          cycles = 0, gap = 0, last_gap = 0, clk_cnt = 0;
  conv_ctrl conv_ctrl_inst (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .global_irq_enable(global_irq_enable),
    .irq_vector_ack(irq_vector_ack), .sleep_noise_halt(sleep_noise_halt), .conv_irq(conv_irq),
    .trigger_flags(trigger_flags), .analog_result(analog_result), .conv_enable(conv_enable),
    .conv_sample(conv_sample), .ref_select(ref_select), .conv_clk_en(conv_clk_en),
    .input_channel_select(input_channel_select), .port_pin_raw(port_pin_raw),
    .pin_input_disable(pin_input_disable), .port_pin_value(port_pin_value));
  always #20 clk_sys = ~clk_sys;
  // Gap between converter clock pulses and pulses since sampling, for timing checks
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    gap <= conv_clk_en ? 1 : gap + 1;
    if (conv_clk_en) last_gap <= gap;
    clk_cnt <= conv_sample ? 0 : clk_cnt + int'(conv_clk_en);
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  // --------------------------------------------------------------------------
  // Bus and check helpers
  // --------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic is_wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h00_0000, wd};
    avs_write <= is_wr;
    avs_read <= !is_wr;
    // No fixed latency assumed; only the cycle ceiling ends a hung request
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    resp = avs_response;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] wd);
    bus(1'b1, idx, wd, v);
  endtask
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, v);
    chk(v, exp);
  endtask
  task automatic wait_irq(output int n);
    int k;
    k = 0;
    while (conv_irq !== 1'b1 && k < 600) begin
      @(posedge clk_sys);
      k++;
    end
    n = clk_cnt;
    chk(conv_irq, 1'b1);
  endtask
  task automatic clr_done;
    @(posedge clk_sys);
    irq_vector_ack <= 1'b1;
    @(posedge clk_sys);
    irq_vector_ack <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(conv_irq, 1'b0);
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs;
    rd_chk(`IDX_CONTROL_A, 8'h00);
    rd_chk(`IDX_RESULT_LOW, 8'h00);
    rd_chk(`IDX_RESULT_HIGH, 8'h00);
    rd_chk(8'h7D, 8'h00);
    chk(resp, 2'b10);
    for (i = 0; i < 16; i++) begin
      r = (i[1:0] == 2'b10) ? 2'b11 : i[1:0];
      wr_reg(`IDX_REF_CHAN, {r, 2'b01, i[3:0]});
      rd_chk(`IDX_REF_CHAN, {r, 2'b00, i[3:0]});
      chk(ref_select, r);
      chk(input_channel_select, i[3:0]);
    end
    $display("test registers done");
  endtask
  task automatic t_div;
    for (i = 0; i < 8; i++) begin
      wr_reg(`IDX_CONTROL_A, 8'h80 | i[7:0]);
      repeat (300) @(posedge clk_sys);
      chk(last_gap, (i < 2) ? 2 : (1 << i));
    end
    $display("test divider done");
  endtask
  task automatic t_conv;
    wr_reg(`IDX_REF_CHAN, 8'h40);
    wr_reg(`IDX_CONTROL_A, 8'hC8);
    rd_chk(`IDX_CONTROL_A, 8'hC8);
    wait_irq(n1);
    rd_chk(`IDX_CONTROL_A, 8'h98);
    clr_done;
    wr_reg(`IDX_CONTROL_A, 8'hC8);
    wr_reg(`IDX_REF_CHAN, 8'hC3);
    repeat (2) @(posedge clk_sys);
    chk(ref_select, 2'b01);
    wait_irq(n2);
    chk(n1 - n2, 12);
    chk(input_channel_select, 4'h3);
    chk(ref_select, 2'b11);
    global_irq_enable <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(conv_irq, 1'b0);
    global_irq_enable <= 1'b1;
    rd_chk(`IDX_RESULT_LOW, 8'hA5);
    rd_chk(`IDX_RESULT_HIGH, 8'h02);
    wr_reg(`IDX_REF_CHAN, 8'hE3);
    rd_chk(`IDX_RESULT_LOW, 8'h40);
    rd_chk(`IDX_RESULT_HIGH, 8'hA9);
    wr_reg(`IDX_CONTROL_A, 8'h98);
    rd_chk(`IDX_CONTROL_A, 8'h88);
    $display("test conversion done");
  endtask
  task automatic t_lock;
    rd_chk(`IDX_RESULT_LOW, 8'h40);
    analog_result <= 10'h155;
    clr_done;
    wr_reg(`IDX_CONTROL_A, 8'hC8);
    wait_irq(n1);
    rd_chk(`IDX_RESULT_HIGH, 8'hA9);
    clr_done;
    wr_reg(`IDX_CONTROL_A, 8'hC8);
    wait_irq(n1);
    rd_chk(`IDX_RESULT_LOW, 8'h40);
    rd_chk(`IDX_RESULT_HIGH, 8'h55);
    clr_done;
    wr_reg(`IDX_CONTROL_A, 8'hC8);
    wr_reg(`IDX_CONTROL_A, 8'h08);
    rd_chk(`IDX_CONTROL_A, 8'h08);
    chk(conv_enable, 1'b0);
    wr_reg(`IDX_PIN_DISABLE, 8'h05);
    repeat (3) @(posedge clk_sys);
    chk(port_pin_value, 6'h3A);
    port_pin_raw <= 6'h2C;
    repeat (3) @(posedge clk_sys);
    chk(port_pin_value, 6'h28);
    chk(pin_input_disable, 6'h05);
    $display("test lock abort pins done");
  endtask
  task automatic t_trig;
    wr_reg(`IDX_CONTROL_B, 8'h01);
    wr_reg(`IDX_CONTROL_A, 8'h88);
    trigger_flags <= 7'h7F;
    repeat (100) @(posedge clk_sys);
    chk(conv_irq, 1'b0);
    trigger_flags <= 7'h00;
    for (i = 1; i < 8; i++) begin
      wr_reg(`IDX_CONTROL_B, i[7:0]);
      wr_reg(`IDX_CONTROL_A, 8'hA8);
      trigger_flags <= 7'h7F & ~(7'h01 << (i - 1));
      repeat (80) @(posedge clk_sys);
      chk(conv_irq, 1'b0);
      trigger_flags <= 7'h7F;
      wait_irq(n1);
      chk(conv_irq, 1'b1);
      trigger_flags <= 7'h00;
      clr_done;
    end
    trigger_flags <= 7'h01;
    wr_reg(`IDX_CONTROL_B, 8'h02);
    wr_reg(`IDX_CONTROL_B, 8'h01);
    wait_irq(n1);
    chk(conv_irq, 1'b1);
    wr_reg(`IDX_CONTROL_B, 8'h00);
    clr_done;
    repeat (100) @(posedge clk_sys);
    chk(conv_irq, 1'b0);
    $display("test triggers done");
  endtask
  task automatic t_modes;
    wr_reg(`IDX_CONTROL_A, 8'hE8);
    wait_irq(n1);
    clr_done;
    wait_irq(n1);
    chk(conv_irq, 1'b1);
    wr_reg(`IDX_CONTROL_A, 8'h08);
    clr_done;
    wr_reg(`IDX_CONTROL_A, 8'h88);
    sleep_noise_halt <= 1'b1;
    wait_irq(n1);
    chk(conv_irq, 1'b1);
    sleep_noise_halt <= 1'b0;
    $display("test modes done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_div();
    t_conv();
    t_lock();
    t_trig();
    t_modes();
    tally_and_finish();
  end
endmodule // test_conv_ctrl
bind conv_ctrl conv_ctrl_assertions conv_ctrl_assertions_inst (.clk_sys(clk_sys), .rst(rst),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response), .conv_irq(conv_irq),
  .global_irq_enable(global_irq_enable), .conv_enable(conv_enable), .conv_sample(conv_sample),
  .ref_select(ref_select), .input_channel_select(input_channel_select),
  .conv_clk_en(conv_clk_en), .pin_input_disable(pin_input_disable),
  .port_pin_value(port_pin_value));
